// file: design/odc_pkg.sv
package odc_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_CONTRAST = 8'hC1;
  localparam logic [7:0] OP_MASTER = 8'hC7;
  localparam logic [7:0] OP_MUX = 8'hCA;
  localparam logic [7:0] OP_ENH = 8'hD1;
  localparam logic [7:0] OP_LOCK = 8'hFD;
  localparam logic [7:0] OP_FUNC = 8'hAB;
  localparam logic [7:0] OP_GRAY = 8'hB8;
  localparam logic [7:0] OP_GRAY_EN = 8'h00;

  // ----------------------------------------------------------------
  // Reset values and parameter fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTRAST_RST = 8'h7F;
  localparam logic [3:0] SCALE_RST = 4'hF;
  localparam logic [6:0] MUX_RST = 7'h7F;
  localparam logic [6:0] MUX_MIN = 7'h0F;
  localparam logic [1:0] ENH_RST = 2'h2;
  localparam logic [1:0] ENH_RSVD = 2'h0;
  localparam logic [7:0] ENH_MASK = 8'hCF;
  localparam logic [7:0] ENH_FIXED = 8'h82;
  localparam logic [7:0] ENH_TAIL = 8'h20;
  localparam logic [7:0] LOCK_RST = 8'h12;
  localparam int LOCK_BIT = 2;
  localparam int VDD_BIT = 0;
  localparam logic VDD_RST = 1'b0;
  localparam int GRAY_LEVELS = 15;
  localparam logic [3:0] GRAY_LAST = 4'hE;
  localparam logic [7:0] GRAY_RST = 8'h00;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_SETTINGS = 8'h08;
  localparam logic [7:0] ADR_GRAY_BASE = 8'h40;
  localparam logic CTRL_RST = 1'b1;
  localparam int SET_SCALE_LSB = 8;
  localparam int SET_MUX_LSB = 16;
  localparam int SET_ENH_LSB = 24;
  localparam int STA_LOCK_BIT = 0;
  localparam int STA_VDD_BIT = 1;
  localparam int STA_PEND_BIT = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic dc;
    logic [7:0] data;
  } odc_byte_t;

  typedef struct packed {
    logic [7:0] contrast;
    logic [3:0] scale;
    logic [6:0] mux;
    logic [1:0] enh;
    logic locked;
    logic vdd_en;
  } odc_cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CONTRAST, ST_MASTER, ST_MUX, ST_ENH1, ST_ENH2,
    ST_LOCK, ST_FUNC, ST_GRAY
  } odc_state_t;

endpackage : odc_pkg

// file: design/odc_cmd_decoder.sv
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module odc_cmd_decoder
  import odc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Host byte stream
  input var odc_byte_t in_byte,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Panel settings
  output odc_cfg_t cfg,
  output logic [7:0] row_count,
  output logic [GRAY_LEVELS-1:0][7:0] gray_level
);

  // --------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------
  function automatic odc_state_t odc_dispatch(input logic [7:0] op);
    case (op)
      OP_CONTRAST: odc_dispatch = ST_CONTRAST;
      OP_MASTER: odc_dispatch = ST_MASTER;
      OP_MUX: odc_dispatch = ST_MUX;
      OP_ENH: odc_dispatch = ST_ENH1;
      OP_LOCK: odc_dispatch = ST_LOCK;
      OP_FUNC: odc_dispatch = ST_FUNC;
      OP_GRAY: odc_dispatch = ST_GRAY;
      default: odc_dispatch = ST_IDLE;
    endcase
  endfunction : odc_dispatch

  function automatic logic odc_cmd_allowed(input logic [7:0] op,
                                           input logic lk);
    odc_cmd_allowed = !lk || (op == OP_LOCK);
  endfunction : odc_cmd_allowed

  // --------------------------------------------------------------
  // Byte classification
  // --------------------------------------------------------------
  logic accept_en;
  logic acc;
  logic is_cmd;
  logic is_par;
  logic cmd_ok;
  odc_state_t st;
  logic [3:0] gray_idx;
  logic gray_pend;
  logic [GRAY_LEVELS-1:0][7:0] gray_stage;
  logic [1:0] enh_pend;
  logic enh_pend_ok;

  assign acc = in_byte.valid && accept_en;
  assign is_cmd = acc && !in_byte.dc;
  assign is_par = acc && in_byte.dc;
  assign cmd_ok = is_cmd && odc_cmd_allowed(in_byte.data, cfg.locked);

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= ST_IDLE;
    end else if (is_cmd) begin
      st <= cmd_ok ? odc_dispatch(in_byte.data) : ST_IDLE;
    end else if (is_par) begin
      case (st)
        ST_ENH1: st <= ST_ENH2;
        ST_GRAY: begin
          if (gray_idx == GRAY_LAST) begin
            st <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Settings
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg.contrast <= CONTRAST_RST;
    end else if (is_par && st == ST_CONTRAST) begin
      cfg.contrast <= in_byte.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg.scale <= SCALE_RST;
    end else if (is_par && st == ST_MASTER) begin
      cfg.scale <= in_byte.data[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg.mux <= MUX_RST;
      row_count <= {1'b0, MUX_RST} + 8'h01;
    end else if (is_par && st == ST_MUX && in_byte.data[6:0] >= MUX_MIN) begin
      cfg.mux <= in_byte.data[6:0];
      row_count <= {1'b0, in_byte.data[6:0]} + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg.enh <= ENH_RST;
      enh_pend <= ENH_RST;
      enh_pend_ok <= 1'b0;
    end else if (is_par && st == ST_ENH1) begin
      enh_pend <= in_byte.data[5:4];
      enh_pend_ok <= ((in_byte.data & ENH_MASK) == ENH_FIXED) &&
                     (in_byte.data[5:4] != ENH_RSVD);
    end else if (is_par && st == ST_ENH2) begin
      if (enh_pend_ok && in_byte.data == ENH_TAIL) begin
        cfg.enh <= enh_pend;
      end
      enh_pend_ok <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg.locked <= LOCK_RST[LOCK_BIT];
    end else if (is_par && st == ST_LOCK) begin
      cfg.locked <= in_byte.data[LOCK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg.vdd_en <= VDD_RST;
    end else if (is_par && st == ST_FUNC) begin
      cfg.vdd_en <= in_byte.data[VDD_BIT];
    end
  end

  // --------------------------------------------------------------
  // Gray-scale table
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      gray_idx <= 4'h0;
      gray_pend <= 1'b0;
    end else if (cmd_ok && in_byte.data == OP_GRAY) begin
      gray_idx <= 4'h0;
      gray_pend <= 1'b0;
    end else if (is_par && st == ST_GRAY) begin
      gray_idx <= gray_idx + 4'h1;
      if (gray_idx == GRAY_LAST) begin
        gray_pend <= 1'b1;
      end
    end else if (cmd_ok && in_byte.data == OP_GRAY_EN) begin
      gray_pend <= 1'b0;
    end
  end

  for (genvar i = 0; i < GRAY_LEVELS; i++) begin : g_gray
    always_ff @(posedge clk) begin
      if (!rstn) begin
        gray_stage[i] <= GRAY_RST;
      end else if (is_par && st == ST_GRAY && gray_idx == 4'(i)) begin
        gray_stage[i] <= in_byte.data;
      end
    end

    always_ff @(posedge clk) begin
      if (!rstn) begin
        gray_level[i] <= GRAY_RST;
      end else if (cmd_ok && in_byte.data == OP_GRAY_EN && gray_pend) begin
        gray_level[i] <= gray_stage[i];
      end
    end
  end

  // --------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------
  logic wb_req;
  logic [31:0] next_rdata;
  logic [7:0] gray_off;

  assign wb_req = wb_cyc_i && wb_stb_i;
  assign gray_off = wb_adr_i - ADR_GRAY_BASE;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      ADR_CTRL: next_rdata[0] = accept_en;
      ADR_STATUS: begin
        next_rdata[STA_LOCK_BIT] = cfg.locked;
        next_rdata[STA_VDD_BIT] = cfg.vdd_en;
        next_rdata[STA_PEND_BIT] = gray_pend;
      end
      ADR_SETTINGS: begin
        next_rdata[7:0] = cfg.contrast;
        next_rdata[SET_SCALE_LSB +: 4] = cfg.scale;
        next_rdata[SET_MUX_LSB +: 7] = cfg.mux;
        next_rdata[SET_ENH_LSB +: 2] = cfg.enh;
      end
      default: begin
        if (wb_adr_i >= ADR_GRAY_BASE && gray_off[1:0] == 2'b00 &&
            gray_off[7:2] < 6'(GRAY_LEVELS)) begin
          next_rdata[7:0] = gray_level[gray_off[5:2]];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      accept_en <= CTRL_RST;
    end else if (wb_req && wb_we_i && wb_ack_o && wb_sel_i[0] &&
                 wb_adr_i == ADR_CTRL) begin
      accept_en <= wb_dat_i[0];
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_par_in(odc_state_t s);
    is_par && st == s;
  endsequence

  sequence s_gray_apply;
    cmd_ok && in_byte.data == OP_GRAY_EN && gray_pend;
  endsequence

  property p_cmd_not_param;
    is_cmd |=> $stable(cfg.contrast) && $stable(cfg.scale);
  endproperty
  a_cmd_not_param: assert property (p_cmd_not_param)
    else $error("opcode byte altered a setting");

  property p_contrast;
    s_par_in(ST_CONTRAST) |=>
      cfg.contrast == $past(in_byte.data) && st == ST_IDLE;
  endproperty
  a_contrast: assert property (p_contrast)
    else $error("contrast not stored");

  property p_scale;
    s_par_in(ST_MASTER) |=> cfg.scale == $past(in_byte.data[3:0]);
  endproperty
  a_scale: assert property (p_scale)
    else $error("master scale not stored");

  property p_mux;
    cfg.mux >= MUX_MIN && row_count == {1'b0, cfg.mux} + 8'h01;
  endproperty
  a_mux: assert property (p_mux)
    else $error("mux ratio out of range or rows wrong");

  property p_enh;
    $changed(cfg.enh) |-> cfg.enh != ENH_RSVD && $past(st) == ST_ENH2;
  endproperty
  a_enh: assert property (p_enh)
    else $error("enhancement changed wrongly");

  property p_lock;
    s_par_in(ST_LOCK) |=> cfg.locked == $past(in_byte.data[LOCK_BIT]);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock bit not taken");

  property p_locked_ignore;
    cfg.locked && is_cmd && in_byte.data != OP_LOCK |=>
      st == ST_IDLE ##1 (st == ST_IDLE || $past(is_cmd));
  endproperty
  a_locked_ignore: assert property (p_locked_ignore)
    else $error("command accepted while locked");

  property p_vdd;
    s_par_in(ST_FUNC) |=> cfg.vdd_en == $past(in_byte.data[VDD_BIT]);
  endproperty
  a_vdd: assert property (p_vdd)
    else $error("regulator enable not taken");

  property p_gray;
    $changed(gray_level) |-> $past(cmd_ok && in_byte.data == OP_GRAY_EN);
  endproperty
  a_gray: assert property (p_gray)
    else $error("gray table changed without 00h");

  property p_gray_apply;
    s_gray_apply |=> gray_level == $past(gray_stage) && !gray_pend;
  endproperty
  a_gray_apply: assert property (p_gray_apply)
    else $error("gray table not applied");

endmodule : odc_cmd_decoder

`default_nettype wire

// file: dv/odc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module odc_host_model
  import odc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Byte stream
  output var odc_byte_t in_byte
);
  initial in_byte = '0;
  // One byte per edge, back to back
  task automatic put(input logic dc, input logic [7:0] d);
    @(posedge clk);
    in_byte <= '{valid: 1'b1, dc: dc, data: d};
  endtask : put
  // Released lines show the inverse of the last byte
  task automatic idle();
    @(posedge clk);
    in_byte <= '{valid: 1'b0, dc: ~in_byte.dc, data: ~in_byte.data};
  endtask : idle
  task automatic enh(input logic [1:0] a);
    put(1'b0, OP_ENH);
    put(1'b1, ENH_FIXED | {2'b00, a, 4'h0});
    put(1'b1, ENH_TAIL);
  endtask : enh
  task automatic gray_load(input logic [GRAY_LEVELS-1:0][7:0] t);
    put(1'b0, OP_GRAY);
    for (int i = 0; i < GRAY_LEVELS; i++) begin
      put(1'b1, t[i]);
    end
  endtask : gray_load
  task automatic init(input logic [7:0] c);
    put(1'b0, OP_LOCK);
    put(1'b1, LOCK_RST);
    put(1'b0, 8'hAE);
    put(1'b0, OP_CONTRAST);
    put(1'b1, c);
    put(1'b0, 8'hAF);
  endtask : init
endmodule : odc_host_model
`default_nettype wire

// file: dv/oled_driver_cmd_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none
module oled_driver_cmd_decoder_test
  import odc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  odc_byte_t in_byte;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  odc_cfg_t cfg;
  logic [7:0] row_count;
  logic [GRAY_LEVELS-1:0][7:0] gray_level;
  logic [GRAY_LEVELS-1:0][7:0] tbl;
  odc_cfg_t e;
  logic pend = 1'b0;
  logic [7:0] s = 8'h16;
  logic [31:0] q;
  int error_cnt = 0;
  int compares = 0;

  always #4 clk = ~clk;

  odc_cmd_decoder u_dut (.clk(clk), .rstn(rstn), .in_byte(in_byte),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg(cfg),
    .row_count(row_count), .gray_level(gray_level));
  odc_host_model u_host (.clk(clk), .in_byte(in_byte));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic [31:0] settings(input odc_cfg_t c);
    return {6'h00, c.enh, 1'b0, c.mux, 4'h0, c.scale, c.contrast};
  endfunction : settings
  task automatic test_done();
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] x);
    wb(1'b0, a, 32'h0000_0000);
    chk(n, q, x);
  endtask : rdchk
  task automatic check_all();
    u_host.idle();
    @(posedge clk);
    chk("cfg", 32'(cfg), 32'(e));
    chk("rows", {24'h0, row_count}, {25'h0, e.mux} + 1);
    rdchk("settings", ADR_SETTINGS, settings(e));
    rdchk("status", ADR_STATUS, {29'h0, pend, e.vdd_en, e.locked});
  endtask : check_all

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    e = '{CONTRAST_RST, SCALE_RST, MUX_RST, ENH_RST, 1'b0, VDD_RST};
    check_all();
    rdchk("ctrl", ADR_CTRL, 32'h0000_0001);
    wb(1'b1, 8'hF0, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'hF0, 32'h0000_0000);
    wb(1'b1, ADR_SETTINGS, 32'h0000_0000);
    for (int k = 0; k < 16; k++) begin
      s = lfsr(s);
      u_host.put(1'b0, OP_CONTRAST);
      u_host.put(1'b1, s);
      e.contrast = s;
      s = lfsr(s);
      u_host.put(1'b0, OP_MASTER);
      u_host.put(1'b1, s);
      e.scale = s[3:0];
      s = (k < 4) ? 8'h0E + 8'(k) : lfsr(s);
      u_host.put(1'b0, OP_MUX);
      u_host.put(1'b1, s);
      if (s[6:0] >= MUX_MIN) e.mux = s[6:0];
      u_host.enh(2'(k));
      if (2'(k) != ENH_RSVD) e.enh = 2'(k);
      u_host.put(1'b0, OP_FUNC);
      u_host.put(1'b1, s);
      e.vdd_en = s[VDD_BIT];
      check_all();
    end
    u_host.put(1'b0, OP_ENH);
    u_host.put(1'b1, 8'h13);
    u_host.put(1'b1, ENH_TAIL);
    u_host.put(1'b0, OP_ENH);
    u_host.put(1'b1, ENH_FIXED | 8'h10);
    u_host.put(1'b1, 8'h21);
    check_all();
    u_host.put(1'b0, OP_LOCK);
    u_host.put(1'b1, 8'h16);
    e.locked = 1'b1;
    u_host.put(1'b0, OP_CONTRAST);
    u_host.put(1'b1, 8'h00);
    u_host.put(1'b0, OP_FUNC);
    u_host.put(1'b1, ~s);
    check_all();
    u_host.put(1'b0, OP_LOCK);
    u_host.put(1'b1, LOCK_RST);
    e.locked = 1'b0;
    check_all();
    for (int i = 0; i < GRAY_LEVELS; i++) begin
      s = lfsr(s);
      tbl[i] = s;
    end
    u_host.gray_load(tbl);
    pend = 1'b1;
    check_all();
    chk("gray_held", 32'(gray_level[0]), 32'h0000_0000);
    u_host.put(1'b0, OP_GRAY_EN);
    pend = 1'b0;
    check_all();
    for (int i = 0; i < GRAY_LEVELS; i++) begin
      rdchk("gray", ADR_GRAY_BASE + 8'(4 * i), 32'(tbl[i]));
    end
    wb(1'b1, ADR_CTRL, 32'h0000_0000);
    u_host.put(1'b0, OP_CONTRAST);
    u_host.put(1'b1, 8'h00);
    check_all();
    wb(1'b1, ADR_CTRL, 32'h0000_0001);
    u_host.init(8'h5A);
    e.contrast = 8'h5A;
    check_all();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : oled_driver_cmd_decoder_test
`default_nettype wire
